/* frame_source.sv */
/* Network side model sending receive frames byte by byte.
   Assumes the caller starts a frame only after the last one ended. */
`timescale 1ns/100ps
module frame_source
(
  input wire logic clock,
  output logic rxValid,
  output logic [7:0] rxData,
  output logic rxLast
);
  initial
  begin
    rxValid = 1'b0;
    rxData = 8'h00;
    rxLast = 1'b0;
  end
  // A slow frame leaves an idle cycle after every odd byte; idle data is scrambled.
  task automatic send(input logic [7:0] q[$], input bit slow);
    for (int i = 0; i < q.size(); i++)
    begin
      @(posedge clock);
      rxValid <= 1'b1;
      rxData <= q[i];
      rxLast <= (i == q.size() - 1);
      if (slow && i[0])
      begin
        @(posedge clock);
        rxValid <= 1'b0;
        rxLast <= 1'b0;
        rxData <= ~q[i];
      end
    end
    @(posedge clock);
    rxValid <= 1'b0;
    rxLast <= 1'b0;
    rxData <= ~rxData;
  endtask
endmodule

/* magic_scan.sv */
/*
  Magic frame scanner: six sync bytes then sixteen copies of the node address.
  Assumes the byte stream starts each frame with the destination address.
*/
`timescale 1ns/100ps
`include "wake_detect_params.svh"
module magic_scan
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clockEn,
  rx_byte_if.sink rx,
  input wake_detect_pkg::node_addr_t nodeAddr,
  output logic found
);
  import wake_detect_pkg::*;

  logic [2:0] syncCnt_q;
  logic [2:0] byteCnt_q;
  logic [4:0] copyCnt_q;
  logic armed_q;
  logic [7:0] want;
  logic isSync;

  assign want = nodeAddr[47 - 8 * byteCnt_q -: 8];
  assign isSync = rx.data == `WD_SYNC_BYTE;

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      syncCnt_q <= 3'h0;
      byteCnt_q <= 3'h0;
      copyCnt_q <= 5'h0;
      armed_q <= 1'b0;
      found <= 1'b0;
    end
    else if (clockEn)
    begin
      if (rx.start)
      begin
        syncCnt_q <= 3'h0;
        byteCnt_q <= 3'h0;
        copyCnt_q <= 5'h0;
        armed_q <= 1'b0;
        found <= 1'b0;
      end
      else if (rx.valid && rx.index >= 11'(`WD_HDR_LEN) && !found)
      begin
        if (armed_q && rx.data == want)
        begin
          if (byteCnt_q == 3'h5)
          begin
            byteCnt_q <= 3'h0;
            copyCnt_q <= copyCnt_q + 5'h1;
            if (copyCnt_q == 5'(`WD_ADDR_COPIES - 1))
              found <= 1'b1;
          end
          else
            byteCnt_q <= byteCnt_q + 3'h1;
        end
        else
        begin
          // A broken run restarts; extra FF bytes keep the sync satisfied.
          byteCnt_q <= 3'h0;
          copyCnt_q <= 5'h0;
          if (isSync)
          begin
            if (syncCnt_q != 3'(`WD_SYNC_LEN))
              syncCnt_q <= syncCnt_q + 3'h1;
            armed_q <= (syncCnt_q >= 3'(`WD_SYNC_LEN - 1));
          end
          else
          begin
            syncCnt_q <= 3'h0;
            armed_q <= 1'b0;
          end
        end
      end
    end
  end
endmodule

/* pattern_crc.sv */
/*
  One pattern filter: CRC-16 over masked bytes from an offset, compared at frame end.
  Assumes frames arrive as a byte stream with a running byte index.
*/
`timescale 1ns/100ps
`include "wake_detect_params.svh"
module pattern_crc
#(
  parameter int MASK_W = `WD_MASK_W
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clockEn,
  rx_byte_if.sink rx,
  input wire logic [7:0] offset,
  input wire logic [MASK_W:0] byteMask,
  input wire logic [15:0] expectedCrc,
  output logic match
);
  import wake_detect_pkg::*;

  initial
  begin
    if (MASK_W < 1 || MASK_W > 31)
      $error("pattern_crc: MASK_W out of range");
  end

  function automatic logic [15:0] crcByte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++)
    begin
      if (r[15] ^ b[i])
        r = (r << 1) ^ `WD_CRC_POLY;
      else
        r = r << 1;
    end
    return r;
  endfunction

  logic [15:0] crc_q;
  logic [11:0] rel;
  logic inWin;

  assign rel = {1'b0, rx.index} - {4'h0, offset};
  // Bytes before the offset wrap to large values and fall outside the window.
  assign inWin = (rel < 12'(MASK_W)) && byteMask[rel[4:0]];

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      crc_q <= `WD_CRC_INIT;
    else if (clockEn)
    begin
      if (rx.start)
        crc_q <= `WD_CRC_INIT;
      else if (rx.valid && inWin)
        crc_q <= crcByte(crc_q, rx.data);
    end
  end

  assign match = (crc_q == expectedCrc);
endmodule

/* rx_byte_if.sv */
/*
  Receive byte stream carrier between the wake detection top and its helpers.
  Assumes one clock; the byte is valid for one cycle while valid is high.
*/
`timescale 1ns/100ps
interface rx_byte_if;
  logic valid;
  logic [7:0] data;
  logic start;
  logic done;
  logic [10:0] index;
  modport source (output valid, output data, output start, output done, output index);
  modport sink (input valid, input data, input start, input done, input index);
endinterface

/* tb_wake_frame_magic_detect.sv */
/* Self-checking bench for the wake detect top.
   Assumes the params header, package and frame source are compiled first. */
`timescale 1ns/100ps
`include "wake_detect_params.svh"
module tb_wake_frame_magic_detect;
  import wake_detect_pkg::*;
  logic clock, rst_n, regWrite, regRead, rxValid, rxLast, rxDeliverEn, irq, power_event_out, ce;
  logic [5:0] regAddr;
  logic [31:0] regWdata, regRdata, rng, m;
  logic [7:0] rxData, ofs;
  logic [47:0] own, dst;
  logic [15:0] crc;
  logic [7:0] fr[$];
  power_state_t powerState;
  int n_fail, checked, cyc;
  bit en, ex;
  wake_frame_magic_detect dut (.clock(clock), .rst_n(rst_n), .clockEn(ce),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .powerState(powerState), .rxValid(rxValid), .rxData(rxData),
    .rxLast(rxLast), .rxDeliverEn(rxDeliverEn), .irq(irq), .power_event_out(power_event_out));
  frame_source src (.clock(clock), .rxValid(rxValid), .rxData(rxData), .rxLast(rxLast));
  task automatic conclude();
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      n_fail++;
      conclude();
    end
  end
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  function automatic logic [7:0] rb();
    return 8'(xs() & 32'h7f);
  endfunction
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
      n_fail++;
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clock);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1 check(regRdata, e);
  endtask
  task automatic mkMagic(input logic [47:0] d, input int copies, input int n);
    fr = {};
    for (int k = 0; k < n; k++)
      fr.push_back(k < 6 ? d[47-8*k -: 8] : rb());
    repeat (6) fr.push_back(8'hff);
    for (int k = 0; k < copies * 6; k++)
      fr.push_back(own[47-8*(k%6) -: 8]);
    repeat (4) fr.push_back(rb());
  endtask
  function automatic bit magicExp();
    bit ok;
    if (!fr[0][0] && {fr[0], fr[1], fr[2], fr[3], fr[4], fr[5]} !== own)
      return 1'b0;
    for (int p = 18; p + 96 <= fr.size(); p++)
    begin
      ok = 1'b1;
      for (int k = 0; k < 102; k++)
        if (fr[p-6+k] !== (k < 6 ? 8'hff : own[47-8*((k-6)%6) -: 8]))
          ok = 1'b0;
      if (ok)
        return 1'b1;
    end
    return 1'b0;
  endfunction
  function automatic logic [15:0] crcOf();
    logic [15:0] c;
    c = `WD_CRC_INIT;
    for (int j = 0; j < 31; j++)
      if (m[j] && ofs + j < fr.size())
        for (int b = 0; b < 8; b++)
          c = (c << 1) ^ ((c[15] ^ fr[ofs+j][b]) ? `WD_CRC_POLY : 16'h0);
    return c;
  endfunction
  initial
  begin
    n_fail = 0;
    checked = 0;
    cyc = 0;
    rng = 32'd57044;
    own = {16'h0246, xs()};
    ce = 1'b1;
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 6'h00;
    regWdata = 32'h0;
    powerState = POWER_FULL;
    rst_n = 1'b0;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    #1 check({irq, power_event_out, rxDeliverEn}, 32'h1);
    rd(`WD_REG_STATUS, 32'h0);
    wr(`WD_REG_ADDR_LO, own[31:0]);
    wr(`WD_REG_ADDR_HI, {16'h0, own[47:32]});
    wr(`WD_REG_MASK, 32'h3);
    wr(`WD_REG_FILT_CMD, 32'h0);
    for (int i = 0; i < 8; i++)
    begin
      en = (i != 5 && i != 6);
      dst = i == 1 ? 48'hffffffffffff : i == 2 ? 48'h01005e0000fb : i == 3 ? own ^ 48'h1 : own;
      wr(`WD_REG_CTRL, {31'h0, en} | 32'hc);
      #1 check(rxDeliverEn, !en);
      powerState <= i == 6 ? POWER_LIGHT_SLEEP : POWER_FULL;
      mkMagic(dst, i == 4 ? 15 : 16, i == 7 ? 6 : 12 + int'(xs() % 5));
      ex = magicExp() && (en || i == 6);
      src.send(fr, i[0]);
      repeat (4) @(posedge clock);
      #1 check({irq, power_event_out}, {ex, ex});
      rd(`WD_REG_STATUS, {31'h0, ex});
      wr(`WD_REG_STATUS, 32'h3);
      #1 check(irq, 1'b0);
    end
    for (int f = 0; f < 6; f++)
    begin
      ofs = 8'd12 + 8'(xs() % 20);
      m = xs() & 32'h7fffffff;
      dst = f[0] ? 48'h01005e000001 : own;
      fr = {};
      for (int k = 0; k < 64; k++)
        fr.push_back(k < 6 ? dst[47-8*k -: 8] : rb());
      crc = crcOf() ^ {15'h0, f == 3};
      ex = f != 3 && f != 4;
      // Last pass runs in light sleep with the pattern enable off.
      powerState <= f == 5 ? POWER_LIGHT_SLEEP : POWER_FULL;
      wr(`WD_REG_CTRL, f >= 4 ? 32'h30 : 32'h32);
      wr(`WD_REG_FILT_CMD, 32'({4'h0, f[0], 3'b001}) << (8 * (f % 4)));
      wr(`WD_REG_FILT_OFS, 32'(ofs) << (8 * (f % 4)));
      wr(`WD_REG_FILT_MASK0 + 6'(f % 4), m);
      wr(`WD_REG_FILT_CRC0 + 6'(f % 4), {16'h0, crc});
      src.send(fr, f[1]);
      repeat (4) @(posedge clock);
      #1 check({irq, power_event_out}, {ex, ex});
      rd(`WD_REG_STATUS, {30'h0, ex, 1'b0});
      wr(`WD_REG_STATUS, 32'h3);
    end
    powerState <= POWER_FULL;
    wr(`WD_REG_FILT_MASK0, 32'hffffffff);
    rd(`WD_REG_FILT_MASK0, 32'h7fffffff);
    wr(`WD_REG_FILT_CMD, 32'hffffffff);
    rd(`WD_REG_FILT_CMD, 32'h09090909);
    wr(`WD_REG_FILT_OFS, 32'h0f0e0d0c);
    rd(`WD_REG_FILT_OFS, 32'h0f0e0d0c);
    // A write while the clock enable is low must leave the register untouched.
    @(posedge clock);
    ce <= 1'b0;
    wr(`WD_REG_FILT_OFS, 32'h55555555);
    @(posedge clock);
    ce <= 1'b1;
    rd(`WD_REG_FILT_OFS, 32'h0f0e0d0c);
    wr(`WD_REG_FILT_CRC0 + 6'h3, 32'hffffabcd);
    rd(`WD_REG_FILT_CRC0 + 6'h3, 32'h0000abcd);
    rd(6'h3f, 32'h0);
    conclude();
  end
endmodule

/* wake_detect_params.svh */
/*
  Constants for the wake detection block: register offsets, field positions, reset values.
  Assumes it is included by bare name from the design files.
*/
`ifndef WAKE_DETECT_PARAMS_SVH
`define WAKE_DETECT_PARAMS_SVH

`define WD_ADDR_W 6
`define WD_REG_CTRL 6'h00
`define WD_REG_STATUS 6'h01
`define WD_REG_MASK 6'h02
`define WD_REG_ADDR_LO 6'h03
`define WD_REG_ADDR_HI 6'h04
`define WD_REG_FILT_CMD 6'h05
`define WD_REG_FILT_OFS 6'h06
`define WD_REG_FILT_MASK0 6'h08
`define WD_REG_FILT_CRC0 6'h0c

`define WD_CTRL_MAGIC_EN 0
`define WD_CTRL_PATTERN_EN 1
`define WD_CTRL_MAGIC_IRQ 2
`define WD_CTRL_MAGIC_PME 3
`define WD_CTRL_PATTERN_IRQ 4
`define WD_CTRL_PATTERN_PME 5
`define WD_CTRL_W 6

`define WD_ST_MAGIC 0
`define WD_ST_PATTERN 1
`define WD_ST_W 2

`define WD_CMD_ENABLE 0
`define WD_CMD_MCAST 3

`define WD_SYNC_BYTE 8'hff
`define WD_SYNC_LEN 6
`define WD_ADDR_COPIES 16
`define WD_HDR_LEN 12
`define WD_CRC_INIT 16'hffff
`define WD_CRC_POLY 16'h8005
`define WD_MASK_W 31

`endif

/* wake_detect_pkg.sv */
/*
  Types shared by the wake detection modules.
  Assumes wake_detect_params.svh is compiled alongside.
*/
package wake_detect_pkg;
  typedef enum logic [1:0] {POWER_FULL, POWER_LIGHT_SLEEP, POWER_OTHER} power_state_t;
  typedef logic [47:0] node_addr_t;
endpackage

/* wake_frame_magic_detect.sv */
/*
  Wake detection top: four pattern filters and a magic frame scanner on the receive path,
  with control, status and interrupt registers on a plain register port.
  Assumes receive bytes are synchronous to clock and rxLast marks a frame's final byte.
*/
// Decided for this implementation: the strobed register port and the placing of the registers.
// Functional notes
// - Each filter has an eight-bit start offset.
// - Computed CRC equal to stored CRC means wake.
// - Magic enable suppresses normal frame delivery.
// - Magic frame found sets the status flag.
// - Report magic via interrupt or power event.
// - Clearing magic enable resumes normal reception.
// - Magic scan accepts own unicast or broadcast.
// - Multicast also accepted when copies found.
// - After addresses, search six FF bytes.
// - Sixteen address copies must follow sync.
// - Full power: magic only while enabled.
// - Light sleep forces both detectors on.
// - Thirty-one bit byte mask selects bytes.
// - Command bit zero enables, bit three multicast.
// - Four filters; address filter plus CRC.
// - Full power: patterns only while enabled.
`timescale 1ns/100ps
`include "wake_detect_params.svh"
module wake_frame_magic_detect
#(
  parameter int FILTERS = 4,
  parameter int MASK_W = `WD_MASK_W
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clockEn,
  input wire logic [`WD_ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata,
  input wire wake_detect_pkg::power_state_t powerState,
  input wire logic rxValid,
  input wire logic [7:0] rxData,
  input wire logic rxLast,
  output logic rxDeliverEn,
  output logic irq,
  output logic power_event_out
);
  import wake_detect_pkg::*;

  initial
  begin
    if (FILTERS != 4)
      $error("wake_frame_magic_detect: register map serves four filters");
    if (MASK_W != 31)
      $error("wake_frame_magic_detect: byte mask must be 31 bits");
  end

  logic [`WD_CTRL_W-1:0] ctrl_q;
  logic [`WD_ST_W-1:0] status_q;
  logic [`WD_ST_W-1:0] irqMask_q;
  node_addr_t nodeAddr_q;
  logic [31:0] filtCmd_q;
  logic [31:0] filtOfs_q;
  logic [31:0] filtMask_q [FILTERS];
  logic [15:0] filtCrc_q [FILTERS];
  logic pmeLatch_q;

  rx_byte_if rx ();
  logic inFrame_q;
  logic [10:0] index_q;
  logic [47:0] dest_q;
  logic [FILTERS-1:0] crcMatch;
  logic magicFound;
  logic magicActive;
  logic patternActive;
  logic magicEvent;
  logic patternEvent;
  logic isBroadcast;
  logic isMulticast;
  logic isOwn;
  logic [FILTERS-1:0] filtHit;
  logic [`WD_ST_W-1:0] stSet;
  logic [`WD_ST_W-1:0] stClear;

  function automatic logic hitReg(input logic [`WD_ADDR_W-1:0] a, input logic [`WD_ADDR_W-1:0] r);
    return regWrite && (a == r);
  endfunction

  // Byte stream with a running index from the first destination byte.
  assign rx.valid = rxValid;
  assign rx.data = rxData;
  assign rx.start = rxValid && !inFrame_q;
  assign rx.done = rxValid && rxLast;
  assign rx.index = inFrame_q ? index_q : 11'h0;

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      inFrame_q <= 1'b0;
      index_q <= 11'h0;
    end
    else if (clockEn && rxValid)
    begin
      inFrame_q <= !rxLast;
      index_q <= rxLast ? 11'h0 : rx.index + 11'h1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      dest_q <= 48'h0;
    else if (clockEn && rxValid && rx.index < 11'h6)
      dest_q <= {dest_q[39:0], rxData};
  end

  assign isBroadcast = &dest_q;
  assign isMulticast = dest_q[40] && !isBroadcast;
  assign isOwn = dest_q == nodeAddr_q;

  assign magicActive = ctrl_q[`WD_CTRL_MAGIC_EN] || powerState == POWER_LIGHT_SLEEP;
  assign patternActive = ctrl_q[`WD_CTRL_PATTERN_EN] || powerState == POWER_LIGHT_SLEEP;

  // Normal delivery stops only while magic mode is selected by software.
  assign rxDeliverEn = !ctrl_q[`WD_CTRL_MAGIC_EN];

  generate
    for (genvar f = 0; f < FILTERS; f++)
    begin : gFilt
      pattern_crc #(.MASK_W(MASK_W)) uCrc (
        .clock(clock),
        .rst_n(rst_n),
        .clockEn(clockEn),
        .rx(rx.sink),
        .offset(filtOfs_q[8*f +: 8]),
        .byteMask(filtMask_q[f]),
        .expectedCrc(filtCrc_q[f]),
        .match(crcMatch[f])
      );
      // Command bit 3 picks multicast-or-broadcast patterns, or own-unicast-only patterns.
      assign filtHit[f] = filtCmd_q[8*f + `WD_CMD_ENABLE] && crcMatch[f] &&
        (filtCmd_q[8*f + `WD_CMD_MCAST] ? (isMulticast || isBroadcast) : isOwn);
    end
  endgenerate

  magic_scan uMagic (
    .clock(clock),
    .rst_n(rst_n),
    .clockEn(clockEn),
    .rx(rx.sink),
    .nodeAddr(nodeAddr_q),
    .found(magicFound)
  );

  // The final byte is absorbed on the edge that sees rxLast, so results are taken one cycle later.
  logic doneDly_q;
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      doneDly_q <= 1'b0;
    else if (clockEn)
      doneDly_q <= rx.done;
  end

  assign magicEvent = doneDly_q && magicActive && magicFound &&
    (isOwn || isBroadcast || isMulticast);
  assign patternEvent = doneDly_q && patternActive && (|filtHit);

  assign stSet = {patternEvent, magicEvent};
  assign stClear = hitReg(regAddr, `WD_REG_STATUS) ? regWdata[`WD_ST_W-1:0] : '0;

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      status_q <= '0;
    else if (clockEn)
      status_q <= (status_q & ~stClear) | stSet;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      ctrl_q <= '0;
    else if (clockEn && hitReg(regAddr, `WD_REG_CTRL))
      ctrl_q <= regWdata[`WD_CTRL_W-1:0];
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      irqMask_q <= '0;
    else if (clockEn && hitReg(regAddr, `WD_REG_MASK))
      irqMask_q <= regWdata[`WD_ST_W-1:0];
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      nodeAddr_q <= 48'h0;
    else if (clockEn && hitReg(regAddr, `WD_REG_ADDR_LO))
      nodeAddr_q[31:0] <= regWdata;
    else if (clockEn && hitReg(regAddr, `WD_REG_ADDR_HI))
      nodeAddr_q[47:32] <= regWdata[15:0];
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      filtCmd_q <= 32'h0;
      filtOfs_q <= 32'h0;
    end
    else if (clockEn && hitReg(regAddr, `WD_REG_FILT_CMD))
      filtCmd_q <= regWdata & 32'h09090909;
    else if (clockEn && hitReg(regAddr, `WD_REG_FILT_OFS))
      filtOfs_q <= regWdata;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      for (int f = 0; f < FILTERS; f++)
      begin
        filtMask_q[f] <= 32'h0;
        filtCrc_q[f] <= 16'h0;
      end
    end
    else if (clockEn && regWrite)
    begin
      for (int f = 0; f < FILTERS; f++)
      begin
        if (regAddr == `WD_REG_FILT_MASK0 + 6'(f))
          filtMask_q[f] <= {1'b0, regWdata[30:0]};
        if (regAddr == `WD_REG_FILT_CRC0 + 6'(f))
          filtCrc_q[f] <= regWdata[15:0];
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      regRdata <= 32'h0;
    else if (clockEn)
    begin
      regRdata <= 32'h0;
      if (regRead)
      begin
        unique case (regAddr)
          `WD_REG_CTRL: regRdata <= 32'(ctrl_q);
          `WD_REG_STATUS: regRdata <= 32'(status_q);
          `WD_REG_MASK: regRdata <= 32'(irqMask_q);
          `WD_REG_ADDR_LO: regRdata <= nodeAddr_q[31:0];
          `WD_REG_ADDR_HI: regRdata <= {16'h0, nodeAddr_q[47:32]};
          `WD_REG_FILT_CMD: regRdata <= filtCmd_q;
          `WD_REG_FILT_OFS: regRdata <= filtOfs_q;
          `WD_REG_FILT_MASK0: regRdata <= filtMask_q[0];
          `WD_REG_FILT_MASK0 + 6'h1: regRdata <= filtMask_q[1];
          `WD_REG_FILT_MASK0 + 6'h2: regRdata <= filtMask_q[2];
          `WD_REG_FILT_MASK0 + 6'h3: regRdata <= filtMask_q[3];
          `WD_REG_FILT_CRC0: regRdata <= {16'h0, filtCrc_q[0]};
          `WD_REG_FILT_CRC0 + 6'h1: regRdata <= {16'h0, filtCrc_q[1]};
          `WD_REG_FILT_CRC0 + 6'h2: regRdata <= {16'h0, filtCrc_q[2]};
          `WD_REG_FILT_CRC0 + 6'h3: regRdata <= {16'h0, filtCrc_q[3]};
          default: regRdata <= 32'h0;
        endcase
      end
    end
  end

  // Interrupt follows the masked sticky bits, gated by the per-event report selects.
  assign irq = |(status_q & irqMask_q &
    {ctrl_q[`WD_CTRL_PATTERN_IRQ], ctrl_q[`WD_CTRL_MAGIC_IRQ]});

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      pmeLatch_q <= 1'b0;
    else if (clockEn)
      pmeLatch_q <= |(status_q & {ctrl_q[`WD_CTRL_PATTERN_PME], ctrl_q[`WD_CTRL_MAGIC_PME]});
  end

  assign power_event_out = pmeLatch_q;
endmodule

/* wake_frame_magic_detect_checker.sv */
/* Port assertions for the wake detect top.
   Assumes clockEn stays high and one clock domain. */
`timescale 1ns/100ps
module wake_frame_magic_detect_checker
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [5:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [31:0] regRdata,
  input wire logic rxLast,
  input wire logic rxDeliverEn,
  input wire logic irq,
  input wire logic power_event_out
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  chk_deliver_off:
    assert property (regWrite && regAddr == 6'h00 && regWdata[0] |=> !rxDeliverEn)
    else $error("delivery still on");
  chk_deliver_on:
    assert property (regWrite && regAddr == 6'h00 && !regWdata[0] |=> rxDeliverEn)
    else $error("delivery not resumed");
  chk_deliver_hold:
    assert property (!$past(regWrite) |-> $stable(rxDeliverEn))
    else $error("delivery changed alone");
  chk_irq_cause:
    assert property ($rose(irq) |-> $past(regWrite) || $past(rxLast, 2) || $past(rxLast, 3)
      || $past(rxLast, 4))
    else $error("irq rose without cause");
  chk_irq_clear:
    assert property ($fell(irq) |-> $past(regWrite))
    else $error("irq fell without write");
  chk_pme_cause:
    assert property ($rose(power_event_out) |-> $past(regWrite, 2) || $past(regWrite)
      || $past(rxLast, 3) || $past(rxLast, 4) || $past(rxLast, 5))
    else $error("event rose without cause");
  chk_mask_top:
    assert property (regRead && regAddr[5:2] == 4'h2 |=> !regRdata[31])
    else $error("mask top bit set");
  chk_cmd_resv:
    assert property (regRead && regAddr == 6'h05 |=> (regRdata & 32'hf6f6f6f6) == 32'h0)
    else $error("command reserved bits set");
  chk_crc_width:
    assert property (regRead && regAddr[5:2] == 4'h3 |=> regRdata[31:16] == 16'h0)
    else $error("crc upper bits set");
  cover property ($rose(irq));
  cover property ($rose(power_event_out));
  cover property ($fell(rxDeliverEn));
endmodule
bind wake_frame_magic_detect wake_frame_magic_detect_checker u_chk (.clock, .rst_n, .regAddr,
  .regWdata, .regWrite, .regRead, .regRdata, .rxLast, .rxDeliverEn, .irq, .power_event_out);
